// ==== core/strap_defs.svh ====
/*
 Strap latch constants: field widths, defaults, special codes and Wishbone offsets.
 Assumes inclusion by bare name from core files.
*/
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH
`define SRC_W              9
`define GP_W               8
`define SRC_HARD_DIFF      9'h09f
`define SRC_HARD_ALT       9'h09e
`define SRC_DEFAULT        9'h1ff
`define GP_DEFAULT         8'hff
`define DRAM_DDR4          1'b0
`define CLK_KIND_DIFF      1'b0
`define ADR_STRAP0         4'h0
`define ADR_STRAP1         4'h4
`define ADR_CTRL           4'h8
`define ADR_ID             4'hc
`define BLANK_WORD         32'hffffffff
`endif

// ==== core/strap_pkg.sv ====
/*
 Types shared by the strap latch.
 Assumes strap_defs.svh sits beside it.
*/
`include "strap_defs.svh"
package strap_pkg;
   typedef struct packed {
      logic [8:0] boot_src;
      logic       xcvr_enable_polarity_sel;
      logic       dram_type;
      logic [7:0] gp;
      logic       ref_clock_kind_sel;
      logic       ref_clock_termination_en;
      logic       ref_clock_spare_strap;
   } strap_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACK  = 3'b010,
      ST_DONE = 3'b100
   } bus_st_t;
endpackage

// ==== core/strap_pin_pad.sv ====
/*
 One shared pin: strap input while reset held, functional driver afterwards.
 Assumes the pad's weak pull-up makes an undriven pin read one.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_pin_pad
(
   input  wire logic in_reset,
   input  wire logic pin_in,
   input  wire logic func_out,
   input  wire logic func_oe_n,
   output logic      strap_level,
   output logic      pin_out,
   output logic      pin_oe_n
);
   // Level taken as is, no inversion for active-low pins
   assign strap_level = pin_in;
   assign pin_out     = func_out;
   // Released while in reset so the board may drive it
   assign pin_oe_n    = in_reset ? 1'b1 : func_oe_n;
endmodule
`default_nettype wire

// ==== core/reset_config_strap_latch.sv ====
/*
 Reset configuration strap latch with a Wishbone status view and one writable control bit.
 Assumes straps on synchronous pins, one clock core_clk, power-on reset sampled as an input.
*/
// Our own choices: the Wishbone slave port and the address map.
// Notes on behaviour
// - sample straps at power-on reset rising edge
// - pins are straps only during reset
// - levels taken literally, high is one
// - undriven strap reads one by pull-up
// - transceiver polarity strap defaults to one
// - memory type zero is DDR4
// - eight general straps, default all ones
// - clock kind: zero differential, one single-ended
// - termination: zero off, one on default
// - codes 9f, 9e pick built-in boot word
// - blank all-ones boot word flagged, undefined
// - latched values stay, pins return normal
`timescale 1ns/10ps
`default_nettype none
`include "strap_defs.svh"
module reset_config_strap_latch
   import strap_pkg::*;
#(
   parameter int NPIN = 22
)
(
   input  wire logic            core_clk,
   input  wire logic            rst_b,
   input  wire logic            power_on_reset_n,
   input  wire logic [NPIN-1:0] strap_pin_in,
   input  wire logic [NPIN-1:0] func_out,
   input  wire logic [NPIN-1:0] func_oe_n,
   output logic      [NPIN-1:0] strap_pin_out,
   output logic      [NPIN-1:0] strap_pin_oe_n,
   input  wire logic [31:0]     boot_word_first,
   input  wire logic            boot_word_valid,
   output strap_t               strap_cfg,
   output logic                 builtin_boot_sel,
   output logic                 boot_word_blank,
   output logic                 flash_bus_xcvr_enable,
   input  wire logic            xcvr_active,
   input  wire logic [3:0]      wb_adr_i,
   input  wire logic [31:0]     wb_dat_i,
   input  wire logic            wb_we_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   output logic [31:0]          wb_dat_o,
   output logic                 wb_ack_o,
   output logic                 wb_err_o
);
   localparam logic [31:0] ID_CODE = 32'h5a5a0001; // Arbitrary value
   logic [NPIN-1:0] level;
   logic [NPIN-1:0] level_r;
   logic            por_d_r;
   logic            por_rise;
   strap_t          strap_r;
   strap_t          sampled;
   logic            blank_r;
   logic            ctrl_r;
   bus_st_t         st_r;
   logic [31:0]     dat_r;
   logic            err_r;

   genvar g;
   generate
      for (g = 0; g < NPIN; g++)
      begin : g_pin
         strap_pin_pad u_pad
         (
            .in_reset    (~power_on_reset_n),
            .pin_in      (strap_pin_in[g]),
            .func_out    (func_out[g]),
            .func_oe_n   (func_oe_n[g]),
            .strap_level (level[g]),
            .pin_out     (strap_pin_out[g]),
            .pin_oe_n    (strap_pin_oe_n[g])
         );
      end
   endgenerate

   // Taken only while reset is low; pads turn around at release
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         level_r <= '1;
      else if (!power_on_reset_n)
         level_r <= level;
   end

   // Pin order: src[8:0], polarity, dram, gp[7:0], kind, term, spare
   assign sampled = strap_t'(level_r);

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         por_d_r <= 1'b0;
      else
         por_d_r <= power_on_reset_n;
   end
   assign por_rise = power_on_reset_n & ~por_d_r;

   // Defaults mirror the pull-ups until the first release
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         strap_r.boot_src                 <= `SRC_DEFAULT;
         strap_r.xcvr_enable_polarity_sel <= 1'b1;
         strap_r.dram_type                <= 1'b1;
         strap_r.gp                       <= `GP_DEFAULT;
         strap_r.ref_clock_kind_sel       <= 1'b1;
         strap_r.ref_clock_termination_en <= 1'b1;
         strap_r.ref_clock_spare_strap    <= 1'b1;
      end
      else if (por_rise)
         strap_r <= sampled;
   end
   assign strap_cfg = strap_r;

   assign builtin_boot_sel = (strap_r.boot_src == `SRC_HARD_DIFF) ||
                             (strap_r.boot_src == `SRC_HARD_ALT);

   // Blank flash cannot be recovered here, only reported
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         blank_r <= 1'b0;
      else if (boot_word_valid && !builtin_boot_sel && boot_word_first == `BLANK_WORD)
         blank_r <= 1'b1;
      else if (por_rise)
         blank_r <= 1'b0;
   end
   assign boot_word_blank = blank_r;

   assign flash_bus_xcvr_enable = xcvr_active ~^ strap_r.xcvr_enable_polarity_sel;

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         ctrl_r <= 1'b0;
      else if (st_r == ST_ACK && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `ADR_CTRL && wb_sel_i[0])
         ctrl_r <= wb_dat_i[0];
   end

   // One wait state before ack, ack dropped the cycle after
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         st_r  <= ST_IDLE;
         dat_r <= 32'h00000000;
         err_r <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            ST_IDLE:
               if (wb_cyc_i && wb_stb_i)
               begin
                  st_r  <= ST_ACK;
                  err_r <= 1'b0;
                  unique case (wb_adr_i)
                     `ADR_STRAP0: dat_r <= {20'h00000, strap_r.gp, 1'b0, strap_r.dram_type,
                                            strap_r.xcvr_enable_polarity_sel, 1'b0};
                     `ADR_STRAP1: dat_r <= {12'h000, strap_r.boot_src, 1'b0, builtin_boot_sel, blank_r,
                                            ctrl_r && strap_r.dram_type != `DRAM_DDR4,
                                            strap_r.ref_clock_spare_strap, strap_r.ref_clock_termination_en,
                                            strap_r.ref_clock_kind_sel, 4'h0};
                     `ADR_CTRL:   dat_r <= {31'h00000000, ctrl_r};
                     `ADR_ID:     dat_r <= ID_CODE;
                     default:
                     begin
                        dat_r <= 32'h00000000;
                        err_r <= 1'b1;
                     end
                  endcase
               end
            ST_ACK:  st_r <= ST_DONE;
            ST_DONE: st_r <= ST_IDLE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end
   assign wb_ack_o = (st_r == ST_ACK) && !err_r;
   assign wb_err_o = (st_r == ST_ACK) && err_r;
   assign wb_dat_o = dat_r;

   property p_latch;
      @(posedge core_clk) disable iff (!rst_b)
      por_rise |=> strap_cfg == $past(sampled);
   endproperty
   a_latch: assert property (p_latch) else $error("straps not latched at release");

   property p_hold;
      @(posedge core_clk) disable iff (!rst_b)
      !por_rise |=> $stable(strap_cfg);
   endproperty
   a_hold: assert property (p_hold) else $error("straps changed outside release");

   property p_pin_release;
      @(posedge core_clk) disable iff (!rst_b)
      !power_on_reset_n |-> &strap_pin_oe_n;
   endproperty
   a_pin_release: assert property (p_pin_release) else $error("pin driven during reset");

   property p_func;
      @(posedge core_clk) disable iff (!rst_b)
      power_on_reset_n |-> strap_pin_oe_n == func_oe_n;
   endproperty
   a_func: assert property (p_func) else $error("function not restored");

   property p_literal;
      @(posedge core_clk) disable iff (!rst_b)
      por_rise |=> strap_cfg.gp == $past(strap_pin_in[10:3], 2);
   endproperty
   a_literal: assert property (p_literal) else $error("strap level inverted");

   property p_default;
      @(posedge core_clk)
      !rst_b |=> strap_cfg.gp == `GP_DEFAULT && strap_cfg.xcvr_enable_polarity_sel
                 && strap_cfg.ref_clock_kind_sel && strap_cfg.ref_clock_termination_en;
   endproperty
   a_default: assert property (p_default) else $error("strap default not one");

   property p_builtin;
      @(posedge core_clk) disable iff (!rst_b)
      builtin_boot_sel |-> strap_cfg.boot_src[8:1] == 8'h4f;
   endproperty
   a_builtin: assert property (p_builtin) else $error("built-in decode wrong");

   property p_blank;
      @(posedge core_clk) disable iff (!rst_b)
      boot_word_valid && !builtin_boot_sel && boot_word_first == `BLANK_WORD |=> boot_word_blank;
   endproperty
   a_blank: assert property (p_blank) else $error("blank word missed");

   property p_polarity;
      @(posedge core_clk) disable iff (!rst_b)
      flash_bus_xcvr_enable == (xcvr_active == strap_cfg.xcvr_enable_polarity_sel);
   endproperty
   a_polarity: assert property (p_polarity) else $error("transceiver polarity wrong");

   property p_ack;
      @(posedge core_clk) disable iff (!rst_b)
      st_r == ST_IDLE && wb_cyc_i && wb_stb_i |=> (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer timing wrong");

   property p_capture;
      @(posedge core_clk) disable iff (!rst_b)
      !power_on_reset_n |=> level_r == $past(strap_pin_in);
   endproperty
   a_capture: assert property (p_capture) else $error("strap level not captured in reset");

   property p_err_map;
      @(posedge core_clk) disable iff (!rst_b)
      st_r == ST_IDLE && wb_cyc_i && wb_stb_i && !(wb_adr_i inside {`ADR_STRAP0, `ADR_STRAP1, `ADR_CTRL, `ADR_ID})
      |=> wb_err_o && !wb_ack_o;
   endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped access not refused");

   property p_dat_hold;
      @(posedge core_clk) disable iff (!rst_b)
      !(st_r == ST_IDLE && wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o);
   endproperty
   a_dat_hold: assert property (p_dat_hold) else $error("read data changed without request");

   property p_gp_view;
      @(posedge core_clk) disable iff (!rst_b)
      st_r == ST_IDLE && wb_cyc_i && wb_stb_i && wb_adr_i == `ADR_STRAP0
      |=> wb_dat_o[11:4] == $past(strap_cfg.gp);
   endproperty
   a_gp_view: assert property (p_gp_view) else $error("general straps read wrong");

   property p_src_view;
      @(posedge core_clk) disable iff (!rst_b)
      st_r == ST_IDLE && wb_cyc_i && wb_stb_i && wb_adr_i == `ADR_STRAP1
      |=> wb_dat_o[19:11] == $past(strap_cfg.boot_src);
   endproperty
   a_src_view: assert property (p_src_view) else $error("boot source read wrong");

   property p_clock_view;
      @(posedge core_clk) disable iff (!rst_b)
      st_r == ST_IDLE && wb_cyc_i && wb_stb_i && wb_adr_i == `ADR_STRAP1
      |=> wb_dat_o[6:4] == $past({strap_cfg.ref_clock_spare_strap, strap_cfg.ref_clock_termination_en,
                                  strap_cfg.ref_clock_kind_sel});
   endproperty
   a_clock_view: assert property (p_clock_view) else $error("clock straps read wrong");

   property p_dram_flag;
      @(posedge core_clk) disable iff (!rst_b)
      st_r == ST_IDLE && wb_cyc_i && wb_stb_i && wb_adr_i == `ADR_STRAP1
      |=> wb_dat_o[7] == $past(ctrl_r && strap_cfg.dram_type != `DRAM_DDR4);
   endproperty
   a_dram_flag: assert property (p_dram_flag) else $error("memory type flag wrong");

   c_release: cover property (@(posedge core_clk) disable iff (!rst_b) por_rise);
   c_builtin: cover property (@(posedge core_clk) disable iff (!rst_b) por_rise ##1 builtin_boot_sel);
   c_blank:   cover property (@(posedge core_clk) disable iff (!rst_b) boot_word_blank);
   c_read:    cover property (@(posedge core_clk) disable iff (!rst_b) wb_ack_o && !wb_we_i);
   c_error:   cover property (@(posedge core_clk) disable iff (!rst_b) wb_err_o);
endmodule
`default_nettype wire

// ==== testbench/strap_board.sv ====
/*
 Board side of the straps: pull-ups plus an optional configuration logic driver.
 Assumes the bench sets the strap pattern while power-on reset is low.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_board
   import strap_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        power_on_reset_n,
   input  wire logic        use_drive,
   input  wire strap_t      straps,
   input  wire logic [21:0] dev_out,
   input  wire logic [21:0] dev_oe_n,
   output logic      [21:0] pin_level
);
   logic [1:0] hold_r;
   logic       drive;
   // Keeps driving two cycles past reset release, then lets go
   always_ff @(posedge core_clk)
   begin
      if (!power_on_reset_n)
         hold_r <= 2'h2;
      else if (hold_r != 2'h0)
         hold_r <= hold_r - 2'h1;
   end
   assign drive = use_drive & (!power_on_reset_n | (hold_r != 2'h0));
   // Released pins go to the pull-up, never keep the last value
   always_comb
   begin
      for (int i = 0; i < 22; i++)
         pin_level[i] = !dev_oe_n[i] ? dev_out[i] : (drive ? straps[i] : 1'b1);
   end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
/*
 Testbench: power-on cycles with board straps, then Wishbone reads of the latched view.
 Assumes strap_board models the shared pins and their pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none
`include "strap_defs.svh"
module tb
   import strap_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        power_on_reset_n = 1'b0;
   logic        use_drive = 1'b0;
   strap_t      straps = '1;
   strap_t      s;
   strap_t      strap_cfg;
   logic [21:0] pin_level;
   logic [21:0] pin_out;
   logic [21:0] pin_oe_n;
   logic [21:0] func_out = 22'h155555;
   logic [21:0] func_oe_n = 22'h0f0f0f;
   logic [31:0] boot_word_first = 32'h0;
   logic        boot_word_valid = 1'b0;
   logic        xcvr_active = 1'b1;
   logic        builtin_boot_sel, boot_word_blank, flash_bus_xcvr_enable;
   logic [3:0]  wb_adr_i = 4'h0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic        wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o, rd;
   logic        wb_ack_o, wb_err_o, er;
   int          fails = 0;
   int          n_checks = 0;
   int          cycles = 0;

   always #10 core_clk = ~core_clk;

   reset_config_strap_latch reset_config_strap_latch_i (.core_clk(core_clk), .rst_b(rst_b),
      .power_on_reset_n(power_on_reset_n), .strap_pin_in(pin_level), .func_out(func_out),
      .func_oe_n(func_oe_n), .strap_pin_out(pin_out), .strap_pin_oe_n(pin_oe_n),
      .boot_word_first(boot_word_first), .boot_word_valid(boot_word_valid), .strap_cfg(strap_cfg),
      .builtin_boot_sel(builtin_boot_sel), .boot_word_blank(boot_word_blank),
      .flash_bus_xcvr_enable(flash_bus_xcvr_enable), .xcvr_active(xcvr_active), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));

   strap_board strap_board_i (.core_clk(core_clk), .power_on_reset_n(power_on_reset_n),
      .use_drive(use_drive), .straps(straps), .dev_out(pin_out), .dev_oe_n(pin_oe_n),
      .pin_level(pin_level));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= 4'hf;
      do
         @(posedge core_clk);
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      wb_sel_i <= 4'h0;
   endtask

   // Board drives eight cycles before release
   task automatic por(input strap_t v, input logic drv);
      @(posedge core_clk);
      power_on_reset_n <= 1'b0;
      straps <= v;
      use_drive <= drv;
      repeat (4) @(posedge core_clk);
      chk({10'h0, pin_oe_n}, 32'h3fffff);
      repeat (4) @(posedge core_clk);
      power_on_reset_n <= 1'b1;
      repeat (6) @(posedge core_clk);
   endtask

   always @(posedge core_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 2000)
      begin
         fails = fails + 1;
         report_and_stop;
      end
   end

   initial
   begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      por('1, 1'b0);
      chk({10'h0, strap_cfg}, 32'h3fffff);
      chk({31'h0, builtin_boot_sel}, 32'h0);
      wb(1'b0, `ADR_STRAP0, 32'h0);
      chk(rd, 32'h00000ff6);
      s = '{9'h09f, 1'b0, 1'b0, 8'h5a, 1'b0, 1'b0, 1'b1};
      por(s, 1'b1);
      func_out <= 22'h2aaaaa;
      repeat (2) @(posedge core_clk);
      chk({10'h0, strap_cfg}, {10'h0, s});
      chk({10'h0, pin_oe_n}, {10'h0, func_oe_n});
      chk({10'h0, pin_out}, 32'h002aaaaa);
      chk({31'h0, builtin_boot_sel}, 32'h1);
      chk({31'h0, flash_bus_xcvr_enable}, 32'h0);
      wb(1'b0, `ADR_STRAP1, 32'h0);
      chk(rd, 32'h0004fa40);
      s = '{9'h09e, 1'b1, 1'b1, 8'h81, 1'b1, 1'b1, 1'b1};
      por(s, 1'b1);
      chk({31'h0, builtin_boot_sel}, 32'h1);
      chk({31'h0, flash_bus_xcvr_enable}, 32'h1);
      wb(1'b1, `ADR_CTRL, 32'h1);
      wb(1'b0, `ADR_CTRL, 32'h0);
      chk(rd, 32'h00000001);
      wb(1'b1, `ADR_STRAP0, 32'h0);
      wb(1'b0, `ADR_STRAP0, 32'h0);
      chk(rd, 32'h00000816);
      wb(1'b0, `ADR_STRAP1, 32'h0);
      chk(rd, 32'h0004f2f0);
      wb(1'b0, 4'h2, 32'h0);
      chk({31'h0, er}, 32'h1);
      por('{9'h100, 1'b1, 1'b0, 8'hff, 1'b1, 1'b1, 1'b1}, 1'b1);
      boot_word_first <= `BLANK_WORD;
      boot_word_valid <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk({31'h0, boot_word_blank}, 32'h1);
      chk({31'h0, builtin_boot_sel}, 32'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
